// File: common/port_status_control_pkg.sv
package port_status_control_pkg;

  // Register map
  localparam logic [11:0] port_status_control_addr = 12'h000;

  // Field positions
  localparam int connect_bit   = 0;
  localparam int enabled_bit   = 1;
  localparam int overcur_bit   = 3;
  localparam int reset_bit     = 4;
  localparam int pls_lo        = 5;
  localparam int pls_hi        = 8;
  localparam int power_bit     = 9;
  localparam int speed_lo      = 10;
  localparam int speed_hi      = 13;
  localparam int strobe_bit    = 16;

  // Reset values and link state codes
  localparam logic [3:0] pls_reset       = 4'h4;
  localparam logic [3:0] pls_disabled    = 4'h4;
  localparam logic [3:0] pls_rx_detect   = 4'h5;
  localparam logic [3:0] speed_undefined = 4'h0;

  // Reset sequence length, cycles of pclk
  localparam int unsigned clk_period_ns    = 100;
  localparam int unsigned reset_time_ns    = 50000;
  localparam int unsigned reset_cycles_def = reset_time_ns / clk_period_ns;

  typedef enum logic [2:0]
  {
    st_idle  = 3'b001,
    st_reset = 3'b010,
    st_done  = 3'b100
  } reset_state_t;

endpackage

// File: hw/port_status_control.sv
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module port_status_control
#(
  parameter int unsigned reset_cycles = port_status_control_pkg::reset_cycles_def,
  parameter bit          usb3_port    = 1'b1,
  parameter bit          power_ctl    = 1'b1
)
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Controller events, same clock
  input  wire logic        controller_reset,
  input  wire logic        max_slots_write,
  // Port side pins
  input  wire logic        device_present_pin,
  input  wire logic [3:0]  device_speed_pin,
  input  wire logic        overcurrent_pin,
  input  wire logic        port_fault_pin,
  input  wire logic        reset_ok_pin,
  input  wire logic [3:0]  link_state_pin,
  // Port control
  output logic             port_power_out,
  output logic             bus_reset_usb2,
  output logic             hot_reset_usb3,
  output logic             link_state_req,
  output logic [3:0]       link_state_req_val
);
  import port_status_control_pkg::*;

  // Reset counter is 16 bits wide
  if (reset_cycles < 1 || reset_cycles > 65535)
  begin
    $error("reset_cycles out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] present_s_q;
  logic [1:0] oc_s_q;
  logic [1:0] fault_s_q;
  logic [1:0] ok_s_q;
  logic [3:0] speed_s1_q;
  logic [3:0] speed_s2_q;
  logic [3:0] speed_s3_q;
  logic [3:0] speed_q;
  logic [3:0] link_s1_q;
  logic [3:0] link_s2_q;
  logic [3:0] link_s3_q;
  logic [3:0] link_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      present_s_q <= 2'h0;
      oc_s_q      <= 2'h0;
      fault_s_q   <= 2'h0;
      ok_s_q      <= 2'h0;
      speed_s1_q  <= 4'h0;
      speed_s2_q  <= 4'h0;
      speed_s3_q  <= speed_undefined;
      link_s1_q   <= pls_reset;
      link_s2_q   <= pls_reset;
      link_s3_q   <= pls_reset;
    end
    else
    begin
      present_s_q <= {present_s_q[0], device_present_pin};
      oc_s_q      <= {oc_s_q[0], overcurrent_pin};
      fault_s_q   <= {fault_s_q[0], port_fault_pin};
      ok_s_q      <= {ok_s_q[0], reset_ok_pin};
      speed_s1_q  <= device_speed_pin;
      speed_s2_q  <= speed_s1_q;
      speed_s3_q  <= speed_s2_q;
      link_s1_q   <= link_state_pin;
      link_s2_q   <= link_s1_q;
      link_s3_q   <= link_s2_q;
    end
  end

  // Multi-bit pins: a word is taken only after two equal samples
  wire speed_steady = (speed_s2_q == speed_s3_q);
  wire link_steady  = (link_s2_q == link_s3_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      speed_q <= speed_undefined;
      link_q  <= pls_reset;
    end
    else
    begin
      if (speed_steady)
        speed_q <= speed_s3_q;
      if (link_steady)
        link_q <= link_s3_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  wire reg_hit  = (paddr[11:2] == port_status_control_addr[11:2]);
  wire wr_fire  = psel && penable && pwrite && reg_hit;
  wire wr_low   = wr_fire && pstrb[0];
  wire wr_mid   = wr_fire && pstrb[1];
  wire wr_hi    = wr_fire && pstrb[2];

  logic             enabled_q;
  logic             power_q;
  logic             reset_req_q;
  logic [3:0]       pls_q;
  reset_state_t     rst_st_q;
  reset_state_t     rst_st_d;
  logic [15:0]      rst_cnt_q;

  wire present     = power_q && present_s_q[1];
  wire oc_active   = oc_s_q[1];
  wire sw_disable  = wr_low && pwdata[enabled_bit];
  wire auto_clear  = !present || fault_s_q[1];
  wire start_reset = wr_low && pwdata[reset_bit] && !reset_req_q && power_q;
  wire pls_write   = wr_low && wr_mid && wr_hi && pwdata[strobe_bit] && power_q;
  wire rst_finish  = (rst_st_q == st_reset) && (rst_cnt_q == 16'h0001);
  wire enable_set  = rst_finish && ok_s_q[1];
  wire power_set   = controller_reset || max_slots_write;
  wire power_clr   = oc_s_q[1] && power_q;
  wire power_wr_en = wr_mid;
  wire [3:0] speed = present ? speed_q : speed_undefined;

  //////////////////////////////////////////////////////////////////////////////
  // Reset sequencer
  always_comb
  begin
    rst_st_d = rst_st_q;
    case (rst_st_q)
      st_idle:  if (start_reset) rst_st_d = st_reset;
      st_reset: if (!power_q) rst_st_d = st_idle;
                else if (rst_finish) rst_st_d = st_done;
      st_done:  rst_st_d = st_idle;
      default:  rst_st_d = st_idle;
    endcase
  end

  // presetn carries cold reset; controller_reset clears synchronously
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_st_q  <= st_idle;
      rst_cnt_q <= 16'h0000;
    end
    else if (controller_reset)
    begin
      rst_st_q  <= st_idle;
      rst_cnt_q <= 16'h0000;
    end
    else
    begin
      rst_st_q <= rst_st_d;
      if (start_reset)
        rst_cnt_q <= 16'(reset_cycles);
      else if (rst_cnt_q != 16'h0000)
        rst_cnt_q <= rst_cnt_q - 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enabled_q   <= 1'b0;
      power_q     <= 1'b0;
      reset_req_q <= 1'b0;
      pls_q       <= pls_reset;
    end
    else if (controller_reset)
    begin
      enabled_q   <= 1'b0;
      power_q     <= 1'b1;
      reset_req_q <= 1'b0;
      pls_q       <= pls_reset;
    end
    else
    begin
      if (power_clr)
        power_q <= 1'b0;
      else if (power_set)
        power_q <= 1'b1;
      else if (power_wr_en && power_ctl)
        power_q <= pwdata[power_bit];

      if (start_reset)
        reset_req_q <= 1'b1;
      else if (rst_finish || !power_q)
        reset_req_q <= 1'b0;

      if (start_reset || auto_clear || !power_q)
        enabled_q <= 1'b0;
      else if (enable_set)
        enabled_q <= 1'b1;
      else if (sw_disable)
        enabled_q <= 1'b0;

      if (pls_write)
        pls_q <= pwdata[pls_hi:pls_lo];
      else if (power_q && !reset_req_q)
        pls_q <= link_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data and outputs; indicator and strobe bits read zero
  wire [31:0] rd_word = {15'h0000, 1'b0, 2'h0, speed, power_q, pls_q, reset_req_q,
                         oc_active, 1'b0, enabled_q, present};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= reg_hit ? rd_word : 32'h0000_0000;
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !reg_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_state_req     <= 1'b0;
      link_state_req_val <= pls_reset;
    end
    else
    begin
      link_state_req <= pls_write;
      if (pls_write)
        link_state_req_val <= pwdata[pls_hi:pls_lo];
    end
  end

  assign port_power_out = power_q;
  assign bus_reset_usb2 = reset_req_q && !usb3_port;
  assign hot_reset_usb3 = reset_req_q && usb3_port;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  no_sw_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!enabled_q && !rst_finish) |=> !enabled_q)
    else $error("port enabled without reset completion");

  sw_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_disable && !enable_set && !controller_reset) |=> !enabled_q)
    else $error("software disable ignored");

  reset_clears_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start_reset && !controller_reset) |=> (reset_req_q && !enabled_q))
    else $error("reset start did not clear enable");

  reset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(reset_req_q) |-> ($past(rst_finish) || !$past(power_q) || $past(controller_reset)))
    else $error("reset bit dropped early");

  reset_unpow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!power_q && !controller_reset) |=> !reset_req_q)
    else $error("reset bit set while unpowered");

  pls_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && !pwdata[strobe_bit] && !power_q && !controller_reset) |=> $stable(pls_q))
    else $error("link state written without strobe");

  strobe_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && reg_hit) |=> (prdata[strobe_bit] == 1'b0))
    else $error("strobe bit read as one");

  oc_power_a: assert property (@(posedge pclk) disable iff (!presetn)
    (power_clr && !controller_reset) |=> !power_q)
    else $error("over-current did not drop power");

  speed_undef_a: assert property (@(posedge pclk) disable iff (!presetn)
    !present |-> (speed == speed_undefined))
    else $error("speed defined without device");

  present_pow_a: assert property (@(posedge pclk) disable iff (!presetn)
    !power_q |-> !present)
    else $error("connect shown while unpowered");

  reset_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start_reset && !controller_reset) |=> (bus_reset_usb2 != hot_reset_usb3))
    else $error("bus reset not driven");

  enable_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (enable_set && !auto_clear && power_q && !controller_reset) |=> enabled_q)
    else $error("reset completion did not enable");

  pls_nostrobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && !pwdata[strobe_bit]) |=> !link_state_req)
    else $error("link request without strobe");

  pls_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pls_write && !controller_reset) |=> (link_state_req && pls_q == $past(pwdata[pls_hi:pls_lo])))
    else $error("link state write not applied");

  power_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (controller_reset || (max_slots_write && !power_clr)) |=> power_q)
    else $error("power flag not set");

  ctl_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    controller_reset |=> (!enabled_q && !reset_req_q && rst_st_q == st_idle))
    else $error("controller reset ignored");

  unpow_pls_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!power_q && !power_set) |=> $stable(pls_q))
    else $error("link state changed while unpowered");

endmodule

// File: verification/usb_device_model.sv
`timescale 1ns/1ns
module usb_device_model
(
  // Testbench controls
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       attach,
  input  wire logic [3:0] speed,
  // Port pins
  input  wire logic       link_state_req,
  input  wire logic [3:0] link_state_req_val,
  output logic            device_present_pin,
  output logic [3:0]      device_speed_pin,
  output logic            reset_ok_pin,
  output logic [3:0]      link_state_pin
);
  // Link follows requested state
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      link_state_pin <= 4'h4;
    else if (link_state_req)
      link_state_pin <= link_state_req_val;
  // Absent device leaves junk on the speed lines
  assign device_speed_pin   = attach ? speed : ~speed;
  assign device_present_pin = attach;
  assign reset_ok_pin       = attach;
endmodule

// File: verification/port_status_control_tb.sv
`timescale 1ns/1ns
module port_status_control_tb;
  import port_status_control_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cres, msw, att, oc, flt, rok, dp, pwr, r2, r3, lreq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, P;
  logic [3:0]  spd, dsp, lpin, lval, pstrb, strb;
  logic        err;
  int          n_fail, checks, cyc, i;
  port_status_control #(.reset_cycles(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .controller_reset(cres), .max_slots_write(msw), .device_present_pin(dp),
    .device_speed_pin(dsp), .overcurrent_pin(oc), .port_fault_pin(flt), .reset_ok_pin(rok),
    .link_state_pin(lpin), .port_power_out(pwr), .bus_reset_usb2(r2), .hot_reset_usb3(r3),
    .link_state_req(lreq), .link_state_req_val(lval));
  usb_device_model dev (.pclk(pclk), .presetn(presetn), .attach(att), .speed(spd), .link_state_req(lreq),
    .link_state_req_val(lval), .device_present_pin(dp), .device_speed_pin(dsp), .reset_ok_pin(rok),
    .link_state_pin(lpin));
  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd(input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, 12'h000, 32'h0);
    chk(rdat & m, e & m);
  endtask
  function logic [31:0] w(logic c, logic e, logic o, logic r, logic [3:0] l, logic p, logic [3:0] s);
    return {18'h0, s, p, l, r, o, 1'b0, e, c};
  endfunction
  task settle;
    repeat (6) @(posedge pclk);
  endtask
  task port_rst;
    xfer(1'b1, 12'h000, P | 32'h10);
    i = 0;
    do begin xfer(1'b0, 12'h000, 32'h0); i++; end while (rdat[reset_bit] && i < 30);
    chk(rdat & 32'h10, 32'h0);
  endtask
  task pulse(input bit hc);
    @(posedge pclk);
    if (hc)
      cres <= 1'b1;
    else
      msw <= 1'b1;
    @(posedge pclk);
    cres <= 1'b0;
    msw <= 1'b0;
    @(negedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (++cyc == 5000)
    begin
      n_fail++;
      report_and_stop;
    end
  initial
  begin
    {presetn, psel, penable, pwrite, cres, msw, att, oc, flt} = '0;
    paddr = '0; pwdata = '0; spd = '0; P = 32'h200;
    pstrb = 4'hF;
    strb = 4'hF;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(w(0, 0, 0, 0, 4'h4, 0, 4'h0), '1);
    xfer(1'b1, 12'h000, 32'h10);
    rd(32'h0, 32'h10);
    pulse(1'b0);
    chk(pwr, 1);
    @(posedge pclk);
    att <= 1'b1;
    for (int s = 1; s <= 4; s++)
    begin
      spd <= s[3:0];
      settle;
      rd(w(1, 0, 0, 0, 4'h4, 1, s[3:0]), '1);
    end
    xfer(1'b1, 12'h000, P | 32'h2);
    rd(32'h0, 32'h2);
    xfer(1'b1, 12'h000, P | 32'h10);
    @(negedge pclk);
    chk({r3, r2}, 2'b10);
    rd(32'h10, 32'h12);
    port_rst;
    rd(32'h2, 32'h12);
    xfer(1'b1, 12'h000, P | 32'h2);
    rd(32'h0, 32'h2);
    port_rst;
    flt <= 1'b1;
    settle;
    rd(32'h0, 32'h2);
    flt <= 1'b0;
    port_rst;
    xfer(1'b1, 12'h000, P | 32'h60);
    @(negedge pclk);
    chk(lreq, 0);
    strb = 4'h3;
    xfer(1'b1, 12'h000, P | 32'h10060);
    @(negedge pclk);
    chk(lreq, 0);
    strb = 4'hF;
    xfer(1'b1, 12'h000, P | 32'h1C060);
    @(negedge pclk);
    chk({lreq, lval}, 5'h13);
    settle;
    rd(w(1, 1, 0, 0, 4'h3, 1, 4'h4), '1);
    att <= 1'b0;
    settle;
    rd(32'h0, 32'h3C03);
    oc <= 1'b1;
    settle;
    rd(32'h8, 32'h208);
    oc <= 1'b0;
    settle;
    rd(32'h0, 32'h8);
    att <= 1'b1;
    settle;
    rd(32'h0, 32'h3C13);
    xfer(1'b0, 12'h004, 32'h0);
    chk({err, rdat}, {1'b1, 32'h0});
    att <= 1'b0;
    settle;
    pulse(1'b1);
    rd(32'h200, 32'hFFFFFE1F);
    report_and_stop;
  end
endmodule
